// ---- aisa_pkg.sv ----
// Constants and carrier types of the audio interrupt status aggregator.
// Assumes a serial control port decoder that turns host frames into
// one-cycle register read and write strobes with a 7-bit address.
package aisa_pkg;

  // ==========================================================
  // Register port widths
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // ==========================================================
  // Register offsets
  localparam logic [6:0] OFF_RX_ERR_FLAGS = 7'h18;
  localparam logic [6:0] OFF_RX_ERR_ENABLE = 7'h19;
  localparam logic [6:0] OFF_CONV_FLAGS = 7'h1a;
  localparam logic [6:0] OFF_CONV_ENABLE = 7'h1b;
  localparam logic [6:0] OFF_TOP_FLAGS = 7'h1c;
  localparam logic [6:0] OFF_TOP_ENABLE = 7'h1d;

  // ==========================================================
  // Converter error register fields
  localparam int unsigned CONV_W = 4;
  localparam int unsigned CONV_STARVE_BIT = 3;
  localparam int unsigned CONV_LEFT_CLIP_BIT = 2;
  localparam int unsigned CONV_RIGHT_CLIP_BIT = 1;
  localparam int unsigned CONV_MUTE_HINT_BIT = 0;
  // Mute hint follows a state; the other three are sticky
  localparam logic [3:0] CONV_STICKY = 4'he;
  // Only bits 2..0 own a mask bit
  localparam logic [3:0] CONV_ENABLE_BITS = 4'h7;

  // ==========================================================
  // Receiver error register fields
  localparam int unsigned RX_ERR_W = 8;
  localparam int unsigned RX_BIPHASE_BIT = 1;
  localparam int unsigned RX_CRC_BIT = 3;
  // Biphase/parity and CRC are sticky; the rest follow a state
  localparam logic [7:0] RX_ERR_STICKY = 8'h0a;

  // ==========================================================
  // Top interrupt status fields
  localparam int unsigned TOP_W = 8;
  localparam int unsigned TOP_CONV_SUM_BIT = 7;
  localparam int unsigned TOP_TX_COLLIDE_BIT = 6;
  localparam int unsigned TOP_TX_UB_EMPTY_BIT = 5;
  localparam int unsigned TOP_TX_CS_SENT_BIT = 4;
  localparam int unsigned TOP_RX_AB_DIFF_BIT = 3;
  localparam int unsigned TOP_RX_UB_NEW_BIT = 2;
  localparam int unsigned TOP_RX_CS_BIT = 1;
  localparam int unsigned TOP_RX_SUM_BIT = 0;
  localparam logic [7:0] TOP_STICKY = 8'hff;
  // Bit 3 is reserved in the mask and never interrupts
  localparam logic [7:0] TOP_ENABLE_BITS = 8'hf7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_RX_ERR_ENABLE = 8'h00;
  localparam logic [7:0] RST_CONV_ENABLE = 8'h00;
  localparam logic [7:0] RST_TOP_ENABLE = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } aisa_req_s;

  typedef struct packed {
    logic conv_starve;
    logic left_clip_flag;
    logic right_clip_flag;
    logic fast_mode_mute_hint;
  } aisa_conv_evt_s;

  typedef struct packed {
    logic tx_cs_host_write;
    logic tx_cs_copy_busy;
    logic tx_user_buffer_empty;
    logic tx_status_block_sent;
    logic rx_status_ab_mismatch;
    logic rx_user_block_new;
    logic rx_status_block_new;
    logic rx_status_changed;
  } aisa_link_evt_s;

endpackage : aisa_pkg

// ---- aisa_flag_bank.sv ----
// Bank of interrupt flags, each either sticky or state-following.
// Assumes events are synchronous to clk and that clr is a one-cycle
// strobe raised while the bank's register is being read.
`timescale 1ns/1ns
module aisa_flag_bank #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] STICKY = '1
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [W-1:0] ev, // pulse (sticky) or level (state)
  input wire logic clr, // read strobe of this register
  output logic [W-1:0] flags, // value seen by a read
  output logic [W-1:0] pend // bits that may raise an interrupt
);
  typedef struct packed {
    logic [W-1:0] flags;
    logic [W-1:0] pend;
  } aisa_bank_state_s;

  aisa_bank_state_s st;
  aisa_bank_state_s next_st;

  if (W < 1 || W > 32)
  begin : g_chk
    $error("aisa_flag_bank: W must be 1 to 32");
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_st = st;
    for (int i = 0; i < W; i++)
    begin
      if (STICKY[i])
      begin
        // An event in the clearing cycle wins over the read
        next_st.flags[i] = ev[i] | (st.flags[i] & ~clr);
        next_st.pend[i] = next_st.flags[i];
      end
      else
      begin
        // A read keeps the level but drops the pending change
        next_st.flags[i] = ev[i];
        next_st.pend[i] = (ev[i] != st.flags[i]) | (st.pend[i] & ~clr);
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign flags = st.flags;
  assign pend = st.pend;

endmodule : aisa_flag_bank

// ---- aisa_irq_aggregator.sv ----
// Interrupt flags, masks and summary logic of an audio codec.
// Assumes a serial control port decoder in front that issues one-cycle
// read and write strobes; the read answer follows one cycle later.
// Event inputs come from the converter, transmitter and receiver.
`timescale 1ns/1ns

module aisa_irq_aggregator
  import aisa_pkg::*;
(
  input wire logic mclk, // system clock, 20 MHz
  input wire logic sys_rst, // async reset, active high
  input wire aisa_pkg::aisa_req_s req, // register read/write strobe
  output logic [aisa_pkg::DATA_W-1:0] rdata, // read data
  output logic rvalid, // read data valid, one cycle
  input wire aisa_pkg::aisa_conv_evt_s conv_evt, // converter events
  input wire logic [aisa_pkg::RX_ERR_W-1:0] rx_err_evt, // receiver events
  input wire aisa_pkg::aisa_link_evt_s link_evt, // tx/rx events
  input wire logic rx_status_change_select, // 1: status bit on change
  output logic irq, // interrupt output, active high
  output logic conv_irq_level // enabled converter flag pending
);
  import aisa_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] rx_err_enable;
    logic [DATA_W-1:0] conv_enable;
    logic [DATA_W-1:0] top_enable;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic irq;
    logic conv_irq;
  } aisa_top_state_s;

  aisa_top_state_s st;
  aisa_top_state_s next_st;

  // ==========================================================
  // Read strobes that clear flags
  logic rd_rx_err;
  logic rd_conv;
  logic rd_top;

  assign rd_rx_err = req.rd && (req.addr == OFF_RX_ERR_FLAGS);
  assign rd_conv = req.rd && (req.addr == OFF_CONV_FLAGS);
  assign rd_top = req.rd && (req.addr == OFF_TOP_FLAGS);

  // ==========================================================
  // Converter error flags
  logic [CONV_W-1:0] conv_ev;
  logic [CONV_W-1:0] conv_flags;
  logic [CONV_W-1:0] conv_pend;

  always_comb
  begin
    conv_ev = '0;
    conv_ev[CONV_STARVE_BIT] = conv_evt.conv_starve;
    conv_ev[CONV_LEFT_CLIP_BIT] = conv_evt.left_clip_flag;
    conv_ev[CONV_RIGHT_CLIP_BIT] = conv_evt.right_clip_flag;
    conv_ev[CONV_MUTE_HINT_BIT] = conv_evt.fast_mode_mute_hint;
  end

  aisa_flag_bank #(
    .W(CONV_W),
    .STICKY(CONV_STICKY)
  ) u_conv_bank (
    .clk(mclk),
    .rst(sys_rst),
    .ev(conv_ev),
    .clr(rd_conv),
    .flags(conv_flags),
    .pend(conv_pend)
  );

  // ==========================================================
  // Receiver error flags
  logic [RX_ERR_W-1:0] rx_flags;
  logic [RX_ERR_W-1:0] rx_pend;

  aisa_flag_bank #(
    .W(RX_ERR_W),
    .STICKY(RX_ERR_STICKY)
  ) u_rx_bank (
    .clk(mclk),
    .rst(sys_rst),
    .ev(rx_err_evt),
    .clr(rd_rx_err),
    .flags(rx_flags),
    .pend(rx_pend)
  );

  // ==========================================================
  // Summary terms
  logic conv_int;
  logic rx_int;

  assign conv_int =
    |(conv_pend & st.conv_enable[CONV_W-1:0] & CONV_ENABLE_BITS);
  assign rx_int = |(rx_pend & st.rx_err_enable);

  // ==========================================================
  // Top interrupt status flags
  logic [TOP_W-1:0] top_ev;
  logic [TOP_W-1:0] top_flags;
  logic [TOP_W-1:0] top_pend;

  always_comb
  begin
    top_ev = '0;
    top_ev[TOP_CONV_SUM_BIT] = conv_int;
    top_ev[TOP_TX_COLLIDE_BIT] =
      link_evt.tx_cs_host_write & link_evt.tx_cs_copy_busy;
    top_ev[TOP_TX_UB_EMPTY_BIT] = link_evt.tx_user_buffer_empty;
    top_ev[TOP_TX_CS_SENT_BIT] = link_evt.tx_status_block_sent;
    top_ev[TOP_RX_AB_DIFF_BIT] = link_evt.rx_status_ab_mismatch;
    top_ev[TOP_RX_UB_NEW_BIT] = link_evt.rx_user_block_new;
    top_ev[TOP_RX_CS_BIT] = rx_status_change_select ?
      link_evt.rx_status_changed : link_evt.rx_status_block_new;
    top_ev[TOP_RX_SUM_BIT] = rx_int;
  end

  aisa_flag_bank #(
    .W(TOP_W),
    .STICKY(TOP_STICKY)
  ) u_top_bank (
    .clk(mclk),
    .rst(sys_rst),
    .ev(top_ev),
    .clr(rd_top),
    .flags(top_flags),
    .pend(top_pend)
  );

  // ==========================================================
  // Read multiplexer
  logic [DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_mux = RST_RDATA;
    case (req.addr)
      OFF_RX_ERR_FLAGS: rd_mux = rx_flags;
      OFF_RX_ERR_ENABLE: rd_mux = st.rx_err_enable;
      OFF_CONV_FLAGS: rd_mux = {{(DATA_W-CONV_W){1'b0}}, conv_flags};
      OFF_CONV_ENABLE:
        rd_mux = {{(DATA_W-CONV_W){1'b0}},
          st.conv_enable[CONV_W-1:0] & CONV_ENABLE_BITS};
      OFF_TOP_FLAGS: rd_mux = top_flags;
      OFF_TOP_ENABLE: rd_mux = st.top_enable & TOP_ENABLE_BITS;
      default: rd_mux = RST_RDATA;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_st = st;
    next_st.rvalid = req.rd;
    if (req.rd)
      next_st.rdata = rd_mux;
    if (req.wr)
    begin
      case (req.addr)
        OFF_RX_ERR_ENABLE: next_st.rx_err_enable = req.wdata;
        // only clip and hint masks are stored
        OFF_CONV_ENABLE:
          next_st.conv_enable = req.wdata &
            {{(DATA_W-CONV_W){1'b0}}, CONV_ENABLE_BITS};
        // reserved mask bit kept at zero
        OFF_TOP_ENABLE: next_st.top_enable = req.wdata & TOP_ENABLE_BITS;
        default: next_st = next_st;
      endcase
    end
    // any enabled status bit drives the output
    next_st.irq = |(top_pend & st.top_enable & TOP_ENABLE_BITS);
    // lets the host see the converter condition directly
    next_st.conv_irq = conv_int;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st.rx_err_enable <= RST_RX_ERR_ENABLE;
      st.conv_enable <= RST_CONV_ENABLE;
      st.top_enable <= RST_TOP_ENABLE;
      st.rdata <= RST_RDATA;
      st.rvalid <= 1'b0;
      st.irq <= 1'b0;
      st.conv_irq <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign rdata = st.rdata;
  assign rvalid = st.rvalid;
  assign irq = st.irq;
  assign conv_irq_level = st.conv_irq;

endmodule : aisa_irq_aggregator

// ---- aisa_irq_checker.sv ----
// Port checker of the interrupt aggregator.
// Assumes read answers one cycle after the strobe, events sampled each edge.
`timescale 1ns/1ns
module aisa_irq_checker
  import aisa_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic sys_rst, // reset
  input wire aisa_pkg::aisa_req_s req, // request
  input wire logic [7:0] rdata, // read data
  input wire logic rvalid, // read valid
  input wire aisa_pkg::aisa_conv_evt_s conv_evt, // converter events
  input wire logic [7:0] rx_err_evt, // receiver events
  input wire aisa_pkg::aisa_link_evt_s link_evt, // link events
  input wire logic rx_status_change_select, // change select
  input wire logic irq, // interrupt
  input wire logic conv_irq_level // converter pending
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic rd_cf;
  logic rd_tf;
  assign rd_cf = req.rd && req.addr == 7'h1a;
  assign rd_tf = req.rd && req.addr == 7'h1c;
  // ==========================================================
  // Sticky converter flags survive until their register is read; the mute hint reads its level
  property p_starve;
    conv_evt.conv_starve ##1 !rd_cf ##1 !rd_cf ##1 !rd_cf ##1 rd_cf
      |=> rdata[3];
  endproperty
  a_starve: assert property (p_starve) else $error("starve lost");
  property p_lclip;
    conv_evt.left_clip_flag ##1 (!rd_cf [*3]) ##1 rd_cf |=> rdata[2];
  endproperty
  a_lclip: assert property (p_lclip) else $error("left clip lost");
  property p_rclip;
    conv_evt.right_clip_flag ##1 (!rd_cf [*3]) ##1 rd_cf |=> rdata[1];
  endproperty
  a_rclip: assert property (p_rclip) else $error("right clip lost");
  property p_hint;
    rd_cf |=> rdata[0] == $past(conv_evt.fast_mode_mute_hint, 2);
  endproperty
  a_hint: assert property (p_hint) else $error("hint wrong");
  // ==========================================================
  // Mask registers keep only their defined bits
  property p_cmask;
    (req.wr && req.addr == 7'h1b) ##1 (req.rd && !req.wr && req.addr == 7'h1b)
      |=> rdata == ($past(req.wdata, 2) & 8'h07);
  endproperty
  a_cmask: assert property (p_cmask) else $error("conv mask wrong");
  property p_tmask;
    (req.wr && req.addr == 7'h1d) ##1 (req.rd && !req.wr && req.addr == 7'h1d)
      |=> rdata == ($past(req.wdata, 2) & 8'hf7);
  endproperty
  a_tmask: assert property (p_tmask) else $error("top mask wrong");
  // ==========================================================
  // Top status events held until the status read
  property p_collide;
    (link_evt.tx_cs_host_write && link_evt.tx_cs_copy_busy) ##1 !rd_tf
      ##1 !rd_tf ##1 rd_tf |=> rdata[6];
  endproperty
  a_collide: assert property (p_collide) else $error("collide lost");
  property p_ubempty;
    link_evt.tx_user_buffer_empty ##1 (!rd_tf [*2]) ##1 rd_tf |=> rdata[5];
  endproperty
  a_ubempty: assert property (p_ubempty) else $error("empty lost");
  property p_csblk;
    (link_evt.rx_status_block_new && !rx_status_change_select)
      ##1 (!rd_tf [*2]) ##1 rd_tf |=> rdata[1];
  endproperty
  a_csblk: assert property (p_csblk) else $error("block lost");
  c_irq: cover property ($rose(irq));
  c_conv: cover property ($rose(conv_irq_level));
  c_read: cover property (rvalid && rdata != 8'h00);
endmodule : aisa_irq_checker

bind aisa_irq_aggregator aisa_irq_checker aisa_irq_checker_i (
  .mclk(mclk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
  .rvalid(rvalid), .conv_evt(conv_evt), .rx_err_evt(rx_err_evt),
  .link_evt(link_evt), .rx_status_change_select(rx_status_change_select),
  .irq(irq), .conv_irq_level(conv_irq_level)
);

// ---- aisa_host_model.sv ----
// Host processor behind the serial control port, as register strobes.
// Assumes each task is entered just after a falling edge of mclk.
`timescale 1ns/1ns
module aisa_host_model
  import aisa_pkg::*;
(
  input wire logic mclk, // clock
  output aisa_pkg::aisa_req_s req, // strobes to the block
  input wire logic [7:0] rdata, // read answer
  input wire logic rvalid // answer valid
);
  initial req = '0;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge mclk);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d,
    output logic v);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge mclk);
    // Answer stands one cycle only, so take it before releasing
    d = rdata;
    v = rvalid;
    req.rd = 1'b0;
    // Idle cycle keeps a following read from re-raising rd at once
    @(negedge mclk);
  endtask : rd
endmodule : aisa_host_model

// ---- tb_top.sv ----
// Self-checking bench of the interrupt aggregator with a host model.
// Assumes a 20 MHz clock; all stimulus moves on the falling edge.
`timescale 1ns/1ns
module tb_top;
  import aisa_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  aisa_req_s req;
  logic [7:0] rdata;
  logic [7:0] rx_err_evt = '0;
  logic rvalid;
  logic irq;
  logic conv_irq_level;
  logic rx_status_change_select = 1'b0;
  aisa_conv_evt_s conv_evt = '0;
  aisa_link_evt_s link_evt = '0;
  int miscompares = 0;
  int checked = 0;
  int tmask;
  int cmask;
  logic [7:0] d;
  logic v;
  // Entries: change select, link event pattern, expected status
  logic [16:0] tbl [9] = '{17'h0c040, 17'h08000, 17'h02020, 17'h01010,
    17'h00808, 17'h00404, 17'h00202, 17'h10200, 17'h10102};
  always #25 mclk = ~mclk;
  aisa_irq_aggregator aisa_irq_aggregator_i (.mclk(mclk), .sys_rst(sys_rst),
    .req(req), .rdata(rdata), .rvalid(rvalid), .conv_evt(conv_evt),
    .rx_err_evt(rx_err_evt), .link_evt(link_evt),
    .rx_status_change_select(rx_status_change_select), .irq(irq),
    .conv_irq_level(conv_irq_level));
  aisa_host_model aisa_host_model_i (.mclk(mclk), .req(req),
    .rdata(rdata), .rvalid(rvalid));
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want)
    begin
      miscompares++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic want);
    checked++;
    if (got !== want)
    begin
      miscompares++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk_bit
  task automatic rdchk(input logic [6:0] a, input logic [7:0] want);
    aisa_host_model_i.rd(a, d, v);
    chk_bit(v, 1'b1);
    chk_byte(d, want);
  endtask : rdchk
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial
  begin
    void'($urandom(88490));
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    rdchk(7'h1b, 8'h00);
    rdchk(7'h1d, 8'h00);
    aisa_host_model_i.wr(7'h1a, 8'hff);
    rdchk(7'h1a, 8'h00);
    rdchk(7'h00, 8'h00);
    // ==========================================================
    // Top status bits, each under a random mask
    foreach (tbl[i])
    begin
      tmask = $urandom;
      rx_status_change_select = tbl[i][16];
      aisa_host_model_i.wr(7'h1d, 8'(tmask));
      tmask &= 8'hf7;
      rdchk(7'h1d, 8'(tmask));
      link_evt = tbl[i][15:8];
      @(negedge mclk);
      link_evt = '0;
      repeat (2) @(negedge mclk);
      chk_bit(irq, |(tbl[i][7:0] & 8'(tmask)));
      rdchk(7'h1c, tbl[i][7:0]);
      rdchk(7'h1c, 8'h00);
      chk_bit(irq, 1'b0);
    end
    // ==========================================================
    // Converter flags reach the summary only when enabled
    aisa_host_model_i.wr(7'h1d, 8'h80);
    @(negedge mclk);
    for (int b = 3; b > 0; b--)
    begin
      cmask = $urandom;
      aisa_host_model_i.wr(7'h1b, 8'(cmask));
      cmask &= 8'h07;
      rdchk(7'h1b, 8'(cmask));
      conv_evt = 4'(1 << b);
      @(negedge mclk);
      conv_evt = '0;
      repeat (3) @(negedge mclk);
      chk_bit(conv_irq_level, cmask[b]);
      chk_bit(irq, cmask[b]);
      rdchk(7'h1a, 8'(1 << b));
      rdchk(7'h1c, {cmask[b], 7'h00});
    end
    aisa_host_model_i.wr(7'h1b, 8'h01);
    conv_evt.fast_mode_mute_hint = 1'b1;
    repeat (3) @(negedge mclk);
    chk_bit(conv_irq_level, 1'b1);
    rdchk(7'h1a, 8'h01);
    rdchk(7'h1a, 8'h01);
    chk_bit(conv_irq_level, 1'b0);
    conv_evt.fast_mode_mute_hint = 1'b0;
    repeat (3) @(negedge mclk);
    rdchk(7'h1a, 8'h00);
    rdchk(7'h1c, 8'h80);
    // ==========================================================
    // Receiver sticky flag through its summary, masked then enabled
    aisa_host_model_i.wr(7'h1d, 8'h01);
    for (int m = 0; m < 2; m++)
    begin
      @(negedge mclk);
      aisa_host_model_i.wr(7'h19, 8'(m * 2));
      rdchk(7'h19, 8'(m * 2));
      rx_err_evt = 8'h02;
      @(negedge mclk);
      rx_err_evt = 8'h00;
      repeat (3) @(negedge mclk);
      chk_bit(irq, m[0]);
      rdchk(7'h18, 8'h02);
      rdchk(7'h18, 8'h00);
      rdchk(7'h1c, {7'h00, m[0]});
    end
    give_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
